// [tb/scp_bus_master.sv]
`timescale 1ns/100ps

module scp_bus_master
(
    input  wire logic clock_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // Four clocks per level, twice what the port must see
    task automatic hold();
        repeat (4) @(posedge clock_in);
    endtask : hold

    task automatic start();
        sda_out <= 1'b1;
        hold();
        scl_out <= 1'b1;
        hold();
        sda_out <= 1'b0;
        hold();
        scl_out <= 1'b0;
        hold();
    endtask : start

    task automatic stop();
        sda_out <= 1'b0;
        hold();
        scl_out <= 1'b1;
        hold();
        sda_out <= 1'b1;
        hold();
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        sda_out <= b;
        hold();
        scl_out <= 1'b1;
        hold();
        r = sda_in;
        hold();
        scl_out <= 1'b0;
        hold();
    endtask : bit_io

    task automatic xfer(input logic [7:0] w, input logic ack, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(ack, a);
    endtask : xfer
endmodule : scp_bus_master

// [tb/scp_props.sv]
`timescale 1ns/100ps

module scp_props
    import scp_pkg::*;
(
    input wire logic             clock_in,
    input wire logic             rstn_in,
    input wire logic             scl_in,
    input wire logic             supply_low_in,
    input wire logic             sda_out,
    input wire logic             sda_oe_out,
    input wire logic [DIV_W-1:0] divider_out,
    input wire logic             divider_load_out,
    input wire logic             pump_current_sel_out,
    input wire logic             testsel_hi_out,
    input wire logic             testsel_mid_out,
    input wire logic             testsel_lo_out,
    input wire logic             refdiv_sel_a_out,
    input wire logic             refdiv_sel_b_out,
    input wire logic [6:0]       refdiv_ratio_out,
    input wire logic             tuning_amp_off_out,
    input wire logic             test_normal_out,
    input wire logic             test_ref_out_out,
    input wire logic             test_half_rate_out,
    input wire logic             test_pd_out,
    input wire logic [BAND_W-1:0] band_port_out,
    input wire logic             por_flag_out
);
    wire logic [2:0] tcode = {testsel_hi_out, testsel_mid_out, testsel_lo_out};
    wire logic [1:0] rsel  = {refdiv_sel_a_out, refdiv_sel_b_out};
    wire logic [3:0] tdec  = {test_normal_out, test_ref_out_out, test_half_rate_out, test_pd_out};

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    property p_ratio;
        $stable(rsel) |-> refdiv_ratio_out ==
            (rsel == 2'h0 ? 7'h0C : rsel == 2'h1 ? 7'h10 : rsel == 2'h2 ? 7'h40 : 7'h50);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio does not follow select");
    property p_test;
        $stable(tcode) |-> tdec == {tcode == 3'h1, tcode[2:1] == 2'h2, tcode == 3'h5, tcode == 3'h0};
    endproperty
    a_test: assert property (p_test) else $error("test decode wrong");
    property p_load;
        divider_load_out |=> !divider_load_out;
    endproperty
    a_load: assert property (p_load) else $error("load pulse too long");
    property p_div;
        $changed(divider_out) |-> divider_load_out || $past(divider_load_out);
    endproperty
    a_div: assert property (p_div) else $error("divider moved without load");
    property p_od;
        sda_out == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_oe;
        $changed(sda_oe_out) |-> !$past(scl_in, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("data drive changed near clock high");
    property p_por_set;
        supply_low_in |-> ##[1:2] por_flag_out;
    endproperty
    a_por_set: assert property (p_por_set) else $error("flag not set by supply");
    property p_por_rise;
        $rose(por_flag_out) |-> $past(supply_low_in) || $past(supply_low_in, 2);
    endproperty
    a_por_rise: assert property (p_por_rise) else $error("flag rose without cause");
    property p_ctl;
        $changed({pump_current_sel_out, tcode, rsel, tuning_amp_off_out, band_port_out})
            |-> !scl_in;
    endproperty
    a_ctl: assert property (p_ctl) else $error("settings changed mid bit");
endmodule : scp_props

bind scp_control_port scp_props u_props (.*);

// [tb/synth_i2c_control_port_tb_top.sv]
`timescale 1ns/100ps

module synth_i2c_control_port_tb_top;
    import scp_pkg::*;

    logic        clock_in;
    logic        rstn_in;
    logic [1:0]  hw_addr;
    logic        lock_flag;
    logic [2:0]  adc_code;
    logic        supply_low;
    logic        scl;
    logic        m_sda;
    logic [7:0]  rd;
    logic        ak;
    int          err_total = 0;
    int          samples_checked = 0;
    wire logic   sda_oe;
    wire logic   sda_d;
    wire logic   sda = m_sda & ~(sda_oe & ~sda_d);
    wire logic [14:0] divider;
    wire logic [7:0]  ctl;
    wire logic [6:0]  ratio;
    wire logic [3:0]  tdec;
    wire logic [3:0]  band;
    wire logic        por;
    assign ctl[7] = 1'b1;

    scp_bus_master u_master (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

    scp_control_port uut
    (
        .clock_in            (clock_in),
        .rstn_in             (rstn_in),
        .scl_in              (scl),
        .sda_in              (sda),
        .hw_addr_in          (hw_addr),
        .lock_flag_in        (lock_flag),
        .adc_code_in         (adc_code),
        .supply_low_in       (supply_low),
        .sda_out             (sda_d),
        .sda_oe_out          (sda_oe),
        .divider_out         (divider),
        .divider_load_out    (),
        .pump_current_sel_out(ctl[6]),
        .testsel_hi_out      (ctl[5]),
        .testsel_mid_out     (ctl[4]),
        .testsel_lo_out      (ctl[3]),
        .refdiv_sel_a_out    (ctl[2]),
        .refdiv_sel_b_out    (ctl[1]),
        .refdiv_ratio_out    (ratio),
        .tuning_amp_off_out  (ctl[0]),
        .test_normal_out     (tdec[3]),
        .test_ref_out_out    (tdec[2]),
        .test_half_rate_out  (tdec[1]),
        .test_pd_out         (tdec[0]),
        .band_port_out       (band),
        .por_flag_out        (por)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic wbyte(input logic [7:0] b, input logic acked);
        u_master.xfer(b, 1'b1, rd, ak);
        check(ak, !acked);
    endtask : wbyte

    task automatic addr(input logic [1:0] hw, input logic rw, input logic acked);
        u_master.start();
        wbyte({ADDR_FIXED, hw, rw}, acked);
    endtask : addr

    function automatic logic [6:0] ratio_f(input logic [1:0] s);
        return s == 2'h0 ? 7'h0C : s == 2'h1 ? 7'h10 : s == 2'h2 ? 7'h40 : 7'h50;
    endfunction : ratio_f

    function automatic logic [3:0] tdec_f(input logic [2:0] t);
        return {t == 3'h1, t[2:1] == 2'h2, t == 3'h5, t == 3'h0};
    endfunction : tdec_f

    function automatic logic [7:0] stat_f(input logic p, input logic l, input logic [2:0] a);
        return {p, l, 3'h7, a > 3'h4 ? 3'h4 : a};
    endfunction : stat_f

    initial
    begin
        repeat (40000) @(posedge clock_in);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test();
    end

    initial
    begin : main
        logic [14:0] d;
        logic [7:0]  c;
        logic [7:0]  bb;
        logic [2:0]  codes [4];
        logic        por_exp;
        codes = '{3'h1, 3'h4, 3'h5, 3'h0};
        void'($urandom(29));
        rstn_in    <= 1'b0;
        hw_addr    <= 2'($urandom);
        lock_flag  <= 1'b0;
        adc_code   <= 3'h0;
        supply_low <= 1'b0;
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        check(divider, DIV_RST);
        check(ctl, CTL_RST);
        check({band, ratio}, {BAND_RST, 7'h50});
        check(por, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            d  = 15'($urandom);
            c  = {1'b1, 1'($urandom), codes[i], 2'(i), 1'($urandom)};
            bb = 8'($urandom);
            addr(hw_addr, 1'b0, 1'b1);
            wbyte({1'b0, d[14:8]}, 1'b1);
            wbyte(d[7:0], 1'b1);
            wbyte(c, 1'b1);
            wbyte(bb, 1'b1);
            u_master.stop();
            check(divider, d);
            check(ctl, c);
            check(tdec, tdec_f(c[5:3]));
            check(ratio, ratio_f(c[2:1]));
            check(band, bb[3:0]);
        end
        $display("write test done");
        d = 15'($urandom);
        addr(hw_addr, 1'b0, 1'b1);
        wbyte(8'h05, 1'b1);
        wbyte(8'hA5, 1'b1);
        wbyte({1'b0, d[14:8]}, 1'b1);
        wbyte(d[7:0], 1'b1);
        wbyte(8'h7F, 1'b1);
        u_master.stop();
        check(divider, d);
        for (int k = 1; k < 4; k++)
            addr(hw_addr ^ 2'(k), 1'b0, 1'b0);
        wbyte(8'h00, 1'b0);
        u_master.stop();
        check(divider, d);
        $display("abort and address test done");
        por_exp = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 6)
            begin
                supply_low <= 1'b1;
                repeat (2) @(posedge clock_in);
                supply_low <= 1'b0;
                @(posedge clock_in);
                check(por, 1'b1);
                por_exp = 1'b1;
            end
            adc_code  <= 3'(i);
            lock_flag <= 1'($urandom);
            @(posedge clock_in);
            addr(hw_addr, 1'b1, 1'b1);
            for (int j = int'(i == 3); j >= 0; j--)
            begin
                u_master.xfer(8'hFF, 1'(j == 0), rd, ak);
                check(rd, stat_f(por_exp, lock_flag, 3'(i)));
                por_exp = 1'b0;
            end
            u_master.stop();
        end
        $display("read test done");
        finish_test();
    end
endmodule : synth_i2c_control_port_tb_top

// [verilog/scp_control_port.sv]
`timescale 1ns/100ps


module scp_control_port
    import scp_pkg::*;
(
    input  wire logic                       clock_in,
    input  wire logic                       rstn_in,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    input  wire logic [1:0]                 hw_addr_in,
    input  wire logic                       lock_flag_in,
    input  wire logic [2:0]                 adc_code_in,
    input  wire logic                       supply_low_in,
    output logic                            sda_out,
    output logic                            sda_oe_out,
    output logic [scp_pkg::DIV_W-1:0]       divider_out,
    output logic                            divider_load_out,
    output logic                            pump_current_sel_out,
    output logic                            testsel_hi_out,
    output logic                            testsel_mid_out,
    output logic                            testsel_lo_out,
    output logic                            refdiv_sel_a_out,
    output logic                            refdiv_sel_b_out,
    output logic [6:0]                      refdiv_ratio_out,
    output logic                            tuning_amp_off_out,
    output logic                            test_normal_out,
    output logic                            test_ref_out_out,
    output logic                            test_half_rate_out,
    output logic                            test_pd_out,
    output logic [scp_pkg::BAND_W-1:0]      band_port_out,
    output logic                            por_flag_out
);
    import scp_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Converter codes above the top level are clamped to the top level
    function automatic logic [2:0] adc_clamp(input logic [2:0] code);
        adc_clamp = (code > ADC_TOP) ? ADC_TOP : code;
    endfunction : adc_clamp

    function automatic logic [7:0] status_byte(input logic por,
                                               input logic lock,
                                               input logic [2:0] adc);
        status_byte = {por, lock, STAT_FILL, adc_clamp(adc)};
    endfunction : status_byte

    function automatic logic [6:0] refdiv_ratio(input logic [1:0] code);
        logic [6:0] r;
        r = REFDIV_11;
        unique case (code)
            2'b00: r = REFDIV_00;
            2'b01: r = REFDIV_01;
            2'b10: r = REFDIV_10;
            2'b11: r = REFDIV_11;
        endcase
        refdiv_ratio = r;
    endfunction : refdiv_ratio

    // ------------------------------------------------------------
    // Bus line events
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    scp_line_mon u_line_mon
    (
        .clock_in     (clock_in),
        .rstn_in      (rstn_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .scl_rise_out (scl_rise),
        .scl_fall_out (scl_fall),
        .start_out    (bus_start),
        .stop_out     (bus_stop)
    );

    // ------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------
    scp_state_e  st_q;
    scp_wbyte_e  wb_q;
    logic [7:0]  sh_q;
    logic [7:0]  tx_q;
    logic [2:0]  cnt_q;
    logic        full_q;
    logic        oe_q;
    logic        addr_match;
    logic        byte_end;
    logic        read_done;
    logic [7:0]  stat_now;

    assign addr_match = (sh_q[7:ADDR_FIXED_POS] == ADDR_FIXED)
                      && (sh_q[ADDR_HW_POS +: 2] == hw_addr_in);
    assign byte_end   = (st_q == ST_WR) && scl_fall && full_q;
    assign read_done  = (st_q == ST_RD) && scl_fall && full_q;
    assign stat_now   = status_byte(por_flag_out, lock_flag_in, adc_code_in);

    // Bit counter and receive shifter; data is sampled on SCL rising
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            sh_q   <= 8'h00;
            cnt_q  <= 3'h0;
            full_q <= 1'b0;
        end
        else if (bus_start || bus_stop)
        begin
            cnt_q  <= 3'h0;
            full_q <= 1'b0;
        end
        else if (scl_rise && (st_q == ST_ADDR || st_q == ST_WR || st_q == ST_RD))
        begin
            sh_q   <= {sh_q[6:0], sda_in};
            cnt_q  <= cnt_q + 3'h1;
            full_q <= (cnt_q == 3'h7);
        end
        else if (scl_fall && full_q)
        begin
            full_q <= 1'b0;
        end
    end

    // Main sequencer; SDA is only changed while SCL is low
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            st_q <= ST_IDLE;
            wb_q <= WB_FIRST;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
        end
        else if (bus_start)
        begin
            st_q <= ST_ADDR;
            wb_q <= WB_FIRST;
            oe_q <= 1'b0;
        end
        else if (bus_stop)
        begin
            // Dropping back to the first byte discards a half pair
            st_q <= ST_IDLE;
            wb_q <= WB_FIRST;
            oe_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    oe_q <= 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_fall && full_q)
                    begin
                        if (addr_match)
                        begin
                            st_q <= ST_ACK_A;
                            oe_q <= 1'b1;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_A:
                begin
                    if (scl_fall)
                    begin
                        if (sh_q[ADDR_RW_POS])
                        begin
                            st_q <= ST_RD;
                            tx_q <= stat_now;
                            oe_q <= ~stat_now[7];
                        end
                        else
                        begin
                            st_q <= ST_WR;
                            oe_q <= 1'b0;
                        end
                    end
                end
                ST_WR:
                begin
                    if (byte_end)
                    begin
                        st_q <= ST_ACK_W;
                        oe_q <= 1'b1;
                        unique case (wb_q)
                            WB_FIRST:
                            begin
                                if (!sh_q[TYPE_POS])
                                begin
                                    wb_q <= WB_DIV2;
                                end
                                else
                                begin
                                    wb_q <= WB_BAND;
                                end
                            end
                            WB_DIV2:
                            begin
                                wb_q <= WB_FIRST;
                            end
                            WB_BAND:
                            begin
                                wb_q <= WB_FIRST;
                            end
                        endcase
                    end
                end
                ST_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        st_q <= ST_WR;
                        oe_q <= 1'b0;
                    end
                end
                ST_RD:
                begin
                    if (scl_fall)
                    begin
                        if (full_q)
                        begin
                            st_q <= ST_RACK;
                            oe_q <= 1'b0;
                        end
                        else
                        begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    // A master that does not acknowledge ends the read
                    if (scl_rise && sda_in)
                    begin
                        st_q <= ST_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        st_q <= ST_RD;
                        tx_q <= stat_now;
                        oe_q <= ~stat_now[7];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Open-drain data pin
    // ------------------------------------------------------------
    // The pin only ever pulls low; the enable carries the data
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            sda_out    <= 1'b0;
            sda_oe_out <= oe_q;
        end
    end

    // ------------------------------------------------------------
    // Divider word
    // ------------------------------------------------------------
    logic [DIV_HI_W-1:0] div_hi_q;

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            div_hi_q         <= DIV_RST[DIV_W-1:8];
            divider_out      <= DIV_RST;
            divider_load_out <= 1'b0;
        end
        else
        begin
            divider_load_out <= 1'b0;
            if (byte_end && wb_q == WB_FIRST && !sh_q[TYPE_POS])
            begin
                // Held aside so the counter never sees a half-written ratio
                div_hi_q <= sh_q[DIV_HI_W-1:0];
            end
            if (byte_end && wb_q == WB_DIV2)
            begin
                divider_out      <= {div_hi_q, sh_q};
                divider_load_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control byte
    // ------------------------------------------------------------
    logic ctl_we;
    assign ctl_we = byte_end && (wb_q == WB_FIRST) && sh_q[TYPE_POS];

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            pump_current_sel_out <= CTL_RST[CTL_PUMP_POS];
            testsel_hi_out       <= CTL_RST[CTL_TEST_POS+2];
            testsel_mid_out      <= CTL_RST[CTL_TEST_POS+1];
            testsel_lo_out       <= CTL_RST[CTL_TEST_POS];
            refdiv_sel_a_out     <= CTL_RST[CTL_SELA_POS];
            refdiv_sel_b_out     <= CTL_RST[CTL_SELB_POS];
            refdiv_ratio_out     <= refdiv_ratio(CTL_RST[CTL_SELA_POS -: 2]);
            tuning_amp_off_out   <= CTL_RST[CTL_AMP_POS];
        end
        else if (ctl_we)
        begin
            pump_current_sel_out <= sh_q[CTL_PUMP_POS];
            testsel_hi_out       <= sh_q[CTL_TEST_POS+2];
            testsel_mid_out      <= sh_q[CTL_TEST_POS+1];
            testsel_lo_out       <= sh_q[CTL_TEST_POS];
            refdiv_sel_a_out     <= sh_q[CTL_SELA_POS];
            refdiv_sel_b_out     <= sh_q[CTL_SELB_POS];
            refdiv_ratio_out     <= refdiv_ratio(sh_q[CTL_SELA_POS -: 2]);
            tuning_amp_off_out   <= sh_q[CTL_AMP_POS];
        end
    end

    // Test-mode decode; unlisted codes leave every test output low
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            test_normal_out    <= (CTL_RST[CTL_TEST_POS +: 3] == TEST_NORMAL);
            test_ref_out_out   <= 1'b0;
            test_half_rate_out <= 1'b0;
            test_pd_out        <= 1'b0;
        end
        else if (ctl_we)
        begin
            test_normal_out    <= (sh_q[CTL_TEST_POS +: 3] == TEST_NORMAL);
            test_ref_out_out   <= (sh_q[CTL_TEST_POS +: 3] == TEST_REF_CNT)
                                || (sh_q[CTL_TEST_POS +: 3] == TEST_REF_HALF);
            test_half_rate_out <= (sh_q[CTL_TEST_POS +: 3] == TEST_REF_HALF);
            test_pd_out        <= (sh_q[CTL_TEST_POS +: 3] == TEST_PD);
        end
    end

    // ------------------------------------------------------------
    // Band outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            band_port_out <= BAND_RST;
        end
        else if (byte_end && wb_q == WB_BAND)
        begin
            band_port_out <= sh_q[BAND_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Power-on flag
    // ------------------------------------------------------------
    // Supply loss beats the read clear, so a dip that overlaps the clear is kept
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            por_flag_out <= 1'b1;
        end
        else if (supply_low_in)
        begin
            por_flag_out <= 1'b1;
        end
        else if (read_done)
        begin
            por_flag_out <= 1'b0;
        end
    end

endmodule : scp_control_port

// [verilog/scp_line_mon.sv]
`timescale 1ns/100ps

module scp_line_mon
(
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rise_out,
    output logic      scl_fall_out,
    output logic      start_out,
    output logic      stop_out
);

    logic scl_q;
    logic sda_q;

    // Idle bus is high on both lines, so no false start after reset
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise_out = scl_in & ~scl_q;
    assign scl_fall_out = ~scl_in & scl_q;
    assign start_out    = scl_q & scl_in & sda_q & ~sda_in;
    assign stop_out     = scl_q & scl_in & ~sda_q & sda_in;

endmodule : scp_line_mon

// [verilog/scp_pkg.sv]
package scp_pkg;

    // ------------------------------------------------------------
    // Address byte
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED      = 5'h18;   // 11000
    localparam int         ADDR_FIXED_POS  = 3;
    localparam int         ADDR_HW_POS     = 1;
    localparam int         ADDR_RW_POS     = 0;

    // ------------------------------------------------------------
    // Data byte fields (bit 7 is the first bit on the wire)
    // ------------------------------------------------------------
    localparam int         TYPE_POS        = 7;
    localparam int         DIV_HI_W        = 7;
    localparam int         DIV_W           = 15;
    localparam int         CTL_PUMP_POS    = 6;
    localparam int         CTL_TEST_POS    = 3;
    localparam int         CTL_SELA_POS    = 2;
    localparam int         CTL_SELB_POS    = 1;
    localparam int         CTL_AMP_POS     = 0;
    localparam int         BAND_W          = 4;

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    localparam logic [2:0] STAT_FILL       = 3'h7;
    localparam logic [2:0] ADC_TOP         = 3'h4;

    // ------------------------------------------------------------
    // Test-mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] TEST_NORMAL     = 3'h1;
    localparam logic [2:0] TEST_REF_CNT    = 3'h4;
    localparam logic [2:0] TEST_REF_HALF   = 3'h5;
    localparam logic [2:0] TEST_PD         = 3'h0;

    // ------------------------------------------------------------
    // Reference divider ratios, indexed by {sel_a, sel_b}
    // ------------------------------------------------------------
    localparam logic [6:0] REFDIV_00       = 7'h0C;
    localparam logic [6:0] REFDIV_01       = 7'h10;
    localparam logic [6:0] REFDIV_10       = 7'h40;
    localparam logic [6:0] REFDIV_11       = 7'h50;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [14:0] DIV_RST        = 15'h0000;
    localparam logic [7:0]  CTL_RST        = 8'h8F;
    localparam logic [3:0]  BAND_RST       = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_A,
        ST_WR,
        ST_ACK_W,
        ST_RD,
        ST_RACK
    } scp_state_e;

    typedef enum logic [1:0] {
        WB_FIRST,
        WB_DIV2,
        WB_BAND
    } scp_wbyte_e;

endpackage : scp_pkg
